// ---- src/tac_pkg.sv ----
// Shared constants and types of the thermal alarm configuration block
package tac_pkg;

   // Register pointers
   localparam logic [3:0] TAC_PTR_CAPS = 4'h0;
   localparam logic [3:0] TAC_PTR_CFG  = 4'h1;

   // Capability field positions
   localparam int TAC_CAP_SD_REL_BIT  = 7;
   localparam int TAC_CAP_TIMEOUT_BIT = 6;
   localparam int TAC_CAP_X_BIT       = 5;
   localparam int TAC_CAP_RES_LSB     = 3;
   localparam int TAC_CAP_RANGE_BIT   = 2;
   localparam int TAC_CAP_ACCUR_BIT   = 1;
   localparam int TAC_CAP_ALARM_BIT   = 0;

   // Configuration field positions
   localparam int TAC_CFG_RST_CLR_BIT = 13;
   localparam int TAC_CFG_RST_OCC_BIT = 12;
   localparam int TAC_CFG_RST_EN_BIT  = 11;
   localparam int TAC_CFG_HYST_LSB    = 9;
   localparam int TAC_CFG_OFF_BIT     = 8;
   localparam int TAC_CFG_CLOCK_BIT   = 7;
   localparam int TAC_CFG_WLOCK_BIT   = 6;
   localparam int TAC_CFG_CLEAR_BIT   = 5;
   localparam int TAC_CFG_STS_BIT     = 4;
   localparam int TAC_CFG_EN_BIT      = 3;
   localparam int TAC_CFG_CONLY_BIT   = 2;
   localparam int TAC_CFG_POL_BIT     = 1;
   localparam int TAC_CFG_MODE_BIT    = 0;

   localparam logic [15:0] TAC_CFG_RESET = 16'h0001;

   // Resolution codes
   localparam logic [1:0] TAC_RES_9B  = 2'h0;
   localparam logic [1:0] TAC_RES_10B = 2'h1;
   localparam logic [1:0] TAC_RES_11B = 2'h2;
   localparam logic [1:0] TAC_RES_12B = 2'h3;

   // Hysteresis in quarter degrees (limit LSB is 0.25 C)
   localparam logic [11:0] TAC_HYST_OFF = 12'h000;
   localparam logic [11:0] TAC_HYST_1P5 = 12'h006;
   localparam logic [11:0] TAC_HYST_3   = 12'h00C;
   localparam logic [11:0] TAC_HYST_6   = 12'h018;

   // Timing
   localparam int TAC_CLK_KHZ       = 25000;
   localparam int TAC_RST_PULSE_MS  = 160;
   localparam int TAC_RST_PULSE_CYC = TAC_RST_PULSE_MS * TAC_CLK_KHZ;
   localparam int TAC_TOUT_MIN_MS   = 25;
   localparam int TAC_TOUT_MAX_MS   = 35;
   localparam int TAC_TOUT_CYC      =
      ((TAC_TOUT_MIN_MS + TAC_TOUT_MAX_MS) / 2) * TAC_CLK_KHZ;

   typedef struct packed {
      logic signed [10:0] upper;
      logic signed [10:0] lower;
      logic signed [10:0] critical;
   } tac_limits_t;

   typedef struct packed {
      logic critical;
      logic above;
      logic below;
   } tac_flags_t;

   typedef struct packed {
      logic       reset_pulse_enable;
      logic [1:0] hyst;
      logic       sensor_shutdown;
      logic       critical_limit_lock;
      logic       window_lock;
      logic       alarm_enable;
      logic       critical_limit_alarm_only;
      logic       alarm_polarity;
      logic       alarm_mode;
   } tac_cfg_t;

endpackage

// ---- src/tac_sync.sv ----
// Two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module tac_sync
#(
   parameter int W = 1
)
(
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   if (W < 1)
   begin : g_chk
      $error("tac_sync: W must be at least one");
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         meta_q   <= '1;
         sync_out <= '1;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ---- src/tac_timer.sv ----
// Restartable one-shot cycle timer
`timescale 1ns/1ps
`default_nettype none
module tac_timer
#(
   parameter int CYC = 16
)
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic start,
   input  wire logic stop,
   output logic      busy,
   output logic      done
);
   localparam int CW = $clog2(CYC + 1);
   localparam logic [CW-1:0] LOAD = CW'(CYC);

   logic [CW-1:0] cnt_q;

   if (CYC < 1)
   begin : g_chk
      $error("tac_timer: CYC must be at least one");
   end

   assign busy = (cnt_q != '0);

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= '0;
         done  <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (stop)
            cnt_q <= '0;
         else if (start)
            cnt_q <= LOAD;
         else if (busy)
         begin
            cnt_q <= cnt_q - CW'(1);
            done  <= (cnt_q == CW'(1));
         end
      end
   end
endmodule
`default_nettype wire

// ---- src/tac_alarm_config.sv ----
// Capability/configuration registers, alarm and overheat reset logic
`timescale 1ns/1ps
`default_nettype none
module tac_alarm_config
   import tac_pkg::*;
#(
   parameter int   RST_PULSE_CYC = TAC_RST_PULSE_CYC,
   parameter int   TIMEOUT_CYC   = TAC_TOUT_CYC,
   parameter logic CAP_SD_REL    = 1'b0,
   parameter logic CAP_TIMEOUT   = 1'b1,
   parameter logic CAP_X         = 1'b1,
   parameter logic CAP_RANGE     = 1'b1,
   parameter logic CAP_ACCURACY  = 1'b1,
   parameter logic CAP_ALARM     = 1'b1
)
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [3:0]  reg_ptr,
   input  wire logic        reg_wr,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   input  wire logic [1:0]  temp_resolution,
   input  wire logic        sample_done,
   input  wire logic signed [10:0] sample_temp,
   input  wire tac_limits_t limits,
   input  wire logic        scl_in,
   output logic             sensor_active,
   output logic             critical_limit_lock,
   output logic             window_lock,
   output tac_flags_t       flags,
   output logic             alarm_o,
   output logic             alarm_oe,
   output logic             overheat_reset_output_o,
   output logic             overheat_reset_output_oe,
   output logic             bus_timeout
);
   tac_cfg_t   cfg_q;
   tac_flags_t flags_d;
   logic       rst_occ_q;
   logic       off_prev_q;
   logic       hold_off_q;
   logic       latch_q;
   logic       window_prev_q;
   logic       crit_seen_q;
   logic       alarm_act_q;
   logic       smp;
   logic       cfg_wr;
   logic       any_lock;
   logic       rst_start;
   logic       rst_busy;
   logic       scl_s;
   logic       scl_prev_q;
   // Signed, else negative temperatures would compare as unsigned
   logic signed [11:0] hyst;
   logic       window_now;

   function automatic logic [11:0] hyst_of(input logic [1:0] code);
      case (code)
         2'h0:    hyst_of = TAC_HYST_OFF;
         2'h1:    hyst_of = TAC_HYST_1P5;
         2'h2:    hyst_of = TAC_HYST_3;
         default: hyst_of = TAC_HYST_6;
      endcase
   endfunction

   function automatic logic signed [11:0] ext(input logic signed [10:0] v);
      ext = {v[10], v};
   endfunction

   if (RST_PULSE_CYC < 1 || TIMEOUT_CYC < 1)
   begin : g_chk
      $error("tac_alarm_config: cycle counts must be positive");
   end

   assign cfg_wr   = reg_wr && (reg_ptr == TAC_PTR_CFG);
   assign any_lock = cfg_q.critical_limit_lock | cfg_q.window_lock;
   assign smp      = sample_done & ~cfg_q.sensor_shutdown;
   assign hyst     = hyst_of(cfg_q.hyst);

   assign sensor_active       = ~cfg_q.sensor_shutdown;
   assign critical_limit_lock = cfg_q.critical_limit_lock;
   assign window_lock         = cfg_q.window_lock;

   // Configuration writes; reserved bits 15,14 are simply not stored
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         cfg_q <= tac_cfg_t'({TAC_CFG_RESET[11:6],
                              TAC_CFG_RESET[3:0]});
      else if (cfg_wr)
      begin
         cfg_q.reset_pulse_enable <= reg_wdata[TAC_CFG_RST_EN_BIT];
         if (!any_lock)
         begin
            cfg_q.hyst <= reg_wdata[TAC_CFG_HYST_LSB +: 2];
            cfg_q.alarm_enable <= reg_wdata[TAC_CFG_EN_BIT];
         end
         if (!reg_wdata[TAC_CFG_OFF_BIT] || !any_lock)
            cfg_q.sensor_shutdown <= reg_wdata[TAC_CFG_OFF_BIT];
         if (reg_wdata[TAC_CFG_CLOCK_BIT])
            cfg_q.critical_limit_lock <= 1'b1;
         if (reg_wdata[TAC_CFG_WLOCK_BIT])
            cfg_q.window_lock <= 1'b1;
         if (!cfg_q.window_lock)
            cfg_q.critical_limit_alarm_only <=
               reg_wdata[TAC_CFG_CONLY_BIT];
         cfg_q.alarm_polarity <= reg_wdata[TAC_CFG_POL_BIT];
         cfg_q.alarm_mode     <= reg_wdata[TAC_CFG_MODE_BIT];
      end
   end

   // Limit flags with hysteresis, judged on each sample taken outside shutdown
   always_comb
   begin
      flags_d = flags;
      if (ext(sample_temp) > ext(limits.critical))
         flags_d.critical = 1'b1;
      else if (ext(sample_temp) <= ext(limits.critical) - hyst)
         flags_d.critical = 1'b0;
      if (ext(sample_temp) > ext(limits.upper))
         flags_d.above = 1'b1;
      else if (ext(sample_temp) <= ext(limits.upper) - hyst)
         flags_d.above = 1'b0;
      if (ext(sample_temp) < ext(limits.lower) - hyst)
         flags_d.below = 1'b1;
      else if (ext(sample_temp) >= ext(limits.lower))
         flags_d.below = 1'b0;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         flags <= '0;
      else if (smp)
         flags <= flags_d;
   end

   assign window_now = flags.above | flags.below;

   // Latched alarm: set on a new window condition, set beats clear
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         latch_q       <= 1'b0;
         window_prev_q <= 1'b0;
      end
      else
      begin
         window_prev_q <= window_now;
         if (window_now && !window_prev_q)
            latch_q <= 1'b1;
         else if (cfg_wr && reg_wdata[TAC_CFG_CLEAR_BIT] &&
                  cfg_q.alarm_mode)
            latch_q <= 1'b0;
         else if (!cfg_q.alarm_mode)
            latch_q <= window_now;
      end
   end

   // Shutdown entry may release the alarm until the next sample
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         off_prev_q <= 1'b0;
         hold_off_q <= 1'b0;
      end
      else
      begin
         off_prev_q <= cfg_q.sensor_shutdown;
         if (cfg_q.sensor_shutdown && !off_prev_q && CAP_SD_REL)
            hold_off_q <= 1'b1;
         else if (smp)
            hold_off_q <= 1'b0;
      end
   end

   // Frozen flags in shutdown keep the output unchanged when not released
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         alarm_act_q <= 1'b0;
      else
         alarm_act_q <= cfg_q.alarm_enable && !hold_off_q &&
            (flags.critical ||
             (!cfg_q.critical_limit_alarm_only &&
              (cfg_q.alarm_mode ? latch_q : window_now)));
   end

   // Open drain: only the low level is driven
   assign alarm_o  = 1'b0;
   assign alarm_oe = ~(alarm_act_q ^ ~cfg_q.alarm_polarity);

   // Overheat reset pulse: critical seen, then below lower limit
   assign rst_start = smp && cfg_q.reset_pulse_enable && crit_seen_q &&
                      !flags_d.critical && flags_d.below && !rst_busy;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         crit_seen_q <= 1'b0;
      else if (smp && flags_d.critical)
         crit_seen_q <= 1'b1;
      else if (rst_start)
         crit_seen_q <= 1'b0;
   end

   tac_timer #(.CYC(RST_PULSE_CYC)) u_rst_pulse
   (
      .mclk  (mclk),
      .rst   (rst),
      .start (rst_start),
      .stop  (1'b0),
      .busy  (rst_busy),
      .done  ()
   );

   // Disabling mid-pulse releases the pin; the status bit is left alone
   assign overheat_reset_output_o  = 1'b0;
   assign overheat_reset_output_oe = rst_busy &&
                                     cfg_q.reset_pulse_enable;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         rst_occ_q <= 1'b0;
      else if (rst_start)
         rst_occ_q <= 1'b1;
      else if (cfg_wr && reg_wdata[TAC_CFG_RST_CLR_BIT])
         rst_occ_q <= 1'b0;
   end

   // Bus timeout: clock line held low too long; runs in shutdown too
   tac_sync #(.W(1)) u_scl_sync
   (
      .mclk     (mclk),
      .rst      (rst),
      .async_in (scl_in),
      .sync_out (scl_s)
   );

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         scl_prev_q <= 1'b1;
      else
         scl_prev_q <= scl_s;
   end

   tac_timer #(.CYC(TIMEOUT_CYC)) u_timeout
   (
      .mclk  (mclk),
      .rst   (rst),
      .start (scl_prev_q && !scl_s),
      .stop  (scl_s),
      .busy  (),
      .done  (bus_timeout)
   );

   // Read data; write-only bits and reserved bits read as zero
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         reg_rdata <= 16'h0000;
      else
         case (reg_ptr)
            TAC_PTR_CAPS:
               reg_rdata <= {8'h00,
                             CAP_SD_REL,
                             CAP_TIMEOUT, CAP_X,
                             temp_resolution,
                             CAP_RANGE, CAP_ACCURACY, CAP_ALARM};
            TAC_PTR_CFG:
               reg_rdata <= {2'h0, 1'b0, rst_occ_q,
                             cfg_q.reset_pulse_enable, cfg_q.hyst,
                             cfg_q.sensor_shutdown,
                             cfg_q.critical_limit_lock, cfg_q.window_lock,
                             1'b0, alarm_act_q,
                             cfg_q.alarm_enable,
                             cfg_q.critical_limit_alarm_only,
                             cfg_q.alarm_polarity, cfg_q.alarm_mode};
            default:
               reg_rdata <= 16'h0000;
         endcase
   end
endmodule
`default_nettype wire

// ---- dv/tac_monitor.sv ----
// Port-level assertions for the alarm configuration block
`timescale 1ns/1ps
`default_nettype none
module tac_monitor
   import tac_pkg::*;
(
   input wire logic               mclk,
   input wire logic               rst,
   input wire logic [3:0]         reg_ptr,
   input wire logic               reg_wr,
   input wire logic [15:0]        reg_wdata,
   input wire logic [15:0]        reg_rdata,
   input wire logic [1:0]         temp_resolution,
   input wire logic               sample_done,
   input wire logic signed [10:0] sample_temp,
   input wire tac_limits_t        limits,
   input wire logic               scl_in,
   input wire logic               sensor_active,
   input wire logic               critical_limit_lock,
   input wire logic               window_lock,
   input wire tac_flags_t         flags,
   input wire logic               bus_timeout
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   a_caps_upper: assert property (reg_ptr == TAC_PTR_CAPS
      |=> reg_rdata[15:8] == 8'h00)
      else $error("capability upper byte not zero");
   a_caps_res: assert property (reg_ptr == TAC_PTR_CAPS
      |=> reg_rdata[4:3] == $past(temp_resolution))
      else $error("resolution field does not follow input");
   a_cfg_rsvd: assert property (reg_ptr == TAC_PTR_CFG
      |=> reg_rdata[15:13] == 3'h0 && !reg_rdata[5])
      else $error("write-only or reserved config bit reads one");
   a_crit_lock: assert property (critical_limit_lock
      |=> critical_limit_lock)
      else $error("critical lock cleared without power-on reset");
   a_win_lock: assert property (window_lock |=> window_lock)
      else $error("window lock cleared without power-on reset");
   a_shutdown_blocked: assert property (
      reg_wr && reg_ptr == TAC_PTR_CFG && reg_wdata[8] && sensor_active
      && (critical_limit_lock || window_lock) |=> sensor_active)
      else $error("shutdown set while locked");
   a_flags_hold: assert property (!sample_done || !sensor_active
      |=> $stable(flags))
      else $error("flags changed without an accepted sample");
   a_crit_set: assert property (
      sample_done && sensor_active && sample_temp > limits.critical
      |=> flags.critical)
      else $error("critical flag not set above limit");
   a_above_set: assert property (
      sample_done && sensor_active && sample_temp > limits.upper
      |=> flags.above)
      else $error("above flag not set over upper limit");
   a_below_clear: assert property (
      sample_done && sensor_active && sample_temp >= limits.lower
      |=> !flags.below)
      else $error("below flag kept at or over lower limit");
   a_timeout_cause: assert property (bus_timeout
      |-> !$past(scl_in, 3))
      else $error("bus timeout while clock line high");
endmodule

bind tac_alarm_config tac_monitor u_mon (
   .mclk(mclk), .rst(rst), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .temp_resolution(temp_resolution), .sample_done(sample_done),
   .sample_temp(sample_temp), .limits(limits), .scl_in(scl_in),
   .sensor_active(sensor_active), .critical_limit_lock(critical_limit_lock),
   .window_lock(window_lock), .flags(flags), .bus_timeout(bus_timeout)
);
`default_nettype wire

// ---- dv/tac_host_model.sv ----
// Bus host model driving the serial clock pin
`timescale 1ns/1ps
`default_nettype none
module tac_host_model
(
   input  wire logic run,
   input  wire logic stall,
   output logic      scl
);
   // Pulled up, so the line stands high between frames
   initial
   begin
      scl = 1'b1;
      #13;
      forever
      begin
         #160;
         if (stall)
            scl = 1'b0;
         else if (run)
            scl = ~scl;
         else
            scl = 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the thermal alarm configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tac_pkg::*;
   localparam int PULSE = 50;
   logic               mclk;
   logic               rst;
   logic [3:0]         reg_ptr;
   logic               reg_wr;
   logic [15:0]        reg_wdata;
   logic [15:0]        reg_rdata;
   logic [1:0]         temp_resolution;
   logic               sample_done;
   logic signed [10:0] sample_temp;
   tac_limits_t        limits;
   logic               scl_in;
   logic               sensor_active;
   logic               crit_lock;
   logic               win_lock;
   tac_flags_t         flags;
   logic               alarm_oe;
   logic               rst_oe;
   logic               bus_timeout;
   logic               run;
   logic               stall;
   logic               seen;
   logic [15:0]        d;
   logic [15:0]        w;
   logic [30:0]        r;
   logic [30:0]        rows [18];
   int                 errors;
   int                 n_compared;
   int                 n;

   tac_alarm_config #(.RST_PULSE_CYC(PULSE), .TIMEOUT_CYC(40)) DUT (
      .mclk(mclk), .rst(rst), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .temp_resolution(temp_resolution), .sample_done(sample_done),
      .sample_temp(sample_temp), .limits(limits), .scl_in(scl_in),
      .sensor_active(sensor_active), .critical_limit_lock(crit_lock),
      .window_lock(win_lock), .flags(flags), .alarm_o(), .alarm_oe(alarm_oe),
      .overheat_reset_output_o(), .overheat_reset_output_oe(rst_oe),
      .bus_timeout(bus_timeout));

   tac_host_model u_host (.run(run), .stall(stall), .scl(scl_in));

   always #20 mclk = ~mclk;

   function automatic logic [15:0] exp_caps(input logic [1:0] res);
      return 16'h0067 | {11'h000, res, 3'h0};
   endfunction

   function automatic logic [15:0] exp_cfg(input logic [15:0] v,
                                           input logic       act);
      return (v & 16'h0F0F) | {11'h000, act, 4'h0};
   endfunction

   task automatic tick();
      @(posedge mclk);
      #1;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      if (errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Strobe dropped and one idle edge, so writes never abut
   task automatic wr(input logic [3:0] p, input logic [15:0] v);
      reg_ptr = p;
      reg_wdata = v;
      reg_wr = 1'b1;
      tick();
      reg_wr = 1'b0;
      tick();
   endtask

   task automatic rd(input logic [3:0] p, output logic [15:0] v);
      reg_ptr = p;
      tick();
      tick();
      v = reg_rdata;
   endtask

   task automatic smp(input logic [10:0] t);
      sample_temp = t;
      sample_done = 1'b1;
      tick();
      sample_done = 1'b0;
      repeat (3) tick();
   endtask

   initial
   begin
      errors = 0;
      n_compared = 0;
      mclk = 1'b0;
      rst = 1'b1;
      reg_ptr = 4'h0;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
      temp_resolution = 2'h1;
      sample_done = 1'b0;
      sample_temp = 11'h000;
      limits = {11'h064, 11'h000, 11'h0C8};
      run = 1'b0;
      stall = 1'b0;
      rows = '{
         {16'h0009, 11'h078, 1'b1, 3'h2}, {16'h0009, 11'h032, 1'b1, 3'h0},
         {16'h0029, 11'h032, 1'b0, 3'h0},
         {16'h0008, 11'h078, 1'b1, 3'h2}, {16'h0008, 11'h032, 1'b0, 3'h0},
         {16'h0008, 11'h7F6, 1'b1, 3'h1}, {16'h0028, 11'h7F6, 1'b1, 3'h1},
         {16'h000D, 11'h078, 1'b0, 3'h2},
         {16'h000D, 11'h0FA, 1'b1, 3'h6}, {16'h000D, 11'h096, 1'b0, 3'h2},
         {16'h000A, 11'h078, 1'b1, 3'h2},
         {16'h0000, 11'h078, 1'b0, 3'h2},
         {16'h0208, 11'h078, 1'b1, 3'h2}, {16'h0208, 11'h062, 1'b1, 3'h2},
         {16'h0208, 11'h05E, 1'b0, 3'h0}, {16'h0208, 11'h7FD, 1'b0, 3'h0},
         {16'h0208, 11'h7F9, 1'b1, 3'h1}, {16'h0208, 11'h7FF, 1'b1, 3'h1}};
      void'($urandom(65119));
      repeat (2) @(posedge mclk);
      #1;
      rst = 1'b0;
      rd(TAC_PTR_CAPS, d);
      check(d | 16'h0020, 16'h006F);
      rd(TAC_PTR_CFG, d);
      check(d, TAC_CFG_RESET);
      check({14'h0, alarm_oe, rst_oe}, 16'h0000);
      wr(TAC_PTR_CAPS, 16'hFFFF);
      for (int k = 0; k < 4; k++)
      begin
         temp_resolution = k[1:0];
         rd(TAC_PTR_CAPS, d);
         check(d | 16'h0020, exp_caps(k[1:0]) | 16'h0020);
      end
      // Locks stay clear here; they cannot be undone later
      repeat (8)
      begin
         w = 16'($urandom);
         w[7:6] = 2'b00;
         wr(TAC_PTR_CFG, w);
         rd(TAC_PTR_CFG, d);
         check(d, exp_cfg(w, 1'b0));
         check({15'h0, alarm_oe}, {15'h0, w[1]});
      end
      wr(TAC_PTR_CFG, 16'h2001);
      foreach (rows[i])
      begin
         r = rows[i];
         wr(TAC_PTR_CFG, r[30:15]);
         smp(r[14:4]);
         check({13'h0, flags}, {13'h0, r[2:0]});
         check({15'h0, alarm_oe}, {15'h0, r[3] ^ r[16]});
         rd(TAC_PTR_CFG, d);
         check(d, exp_cfg(r[30:15], r[3]));
      end
      wr(TAC_PTR_CFG, 16'h0800);
      smp(11'h0FA);
      sample_temp = 11'h7F6;
      sample_done = 1'b1;
      tick();
      sample_done = 1'b0;
      for (n = 0; n < 4 && rst_oe !== 1'b1; n++)
         tick();
      check({15'h0, rst_oe}, 16'h0001);
      if (rst_oe !== 1'b1)
         conclude();
      for (n = 0; rst_oe === 1'b1 && n < 200; n++)
         tick();
      check(16'(n), 16'(PULSE));
      if (n == 200)
         conclude();
      rd(TAC_PTR_CFG, d);
      check(d, 16'h1800);
      wr(TAC_PTR_CFG, 16'h2800);
      rd(TAC_PTR_CFG, d);
      check(d, 16'h0800);
      wr(TAC_PTR_CFG, 16'h0000);
      smp(11'h0FA);
      smp(11'h7F6);
      check({15'h0, rst_oe}, 16'h0000);
      rd(TAC_PTR_CFG, d);
      check(d, 16'h0000);
      wr(TAC_PTR_CFG, 16'h0100);
      smp(11'h0FA);
      check({12'h0, sensor_active, flags}, 16'h0001);
      run = 1'b1;
      seen = 1'b0;
      repeat (60)
      begin
         tick();
         seen = seen | bus_timeout;
      end
      check({15'h0, seen}, 16'h0000);
      stall = 1'b1;
      for (n = 0; n < 100 && bus_timeout !== 1'b1; n++)
         tick();
      check({15'h0, bus_timeout}, 16'h0001);
      if (n == 100)
         conclude();
      stall = 1'b0;
      run = 1'b0;
      wr(TAC_PTR_CFG, 16'h01C0);
      check({14'h0, crit_lock, win_lock}, 16'h0003);
      wr(TAC_PTR_CFG, 16'h0F3F);
      rd(TAC_PTR_CFG, d);
      check(d, 16'h09C3);
      wr(TAC_PTR_CFG, 16'h0000);
      rd(TAC_PTR_CFG, d);
      check(d, 16'h00C0);
      wr(TAC_PTR_CFG, 16'h0100);
      rd(TAC_PTR_CFG, d);
      check(d, 16'h00C0);
      conclude();
   end
endmodule
`default_nettype wire
